// *** hdl/dip_restart_defines.svh ***
// Constants for the power dip restart sequencer
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
// Summary of operation
// R1: Undervoltage while running starts dip handling
// R2: Mode 0 trips at once with alarm
// R3: Mode 1 alarms only after supply recovers
// R4: Mode 4 saves frequency, restarts there on run
// R5: Mode 4 limiter slows to speed, then reaccelerates
// R6: Configurer enables surge current limiter for mode 4
// R7: Mode 5 restarts at starting frequency
// R8: At least half second before any restart
// R9: Two second run window, later runs start fresh
// R10: Outside circuitry reasserts run within two seconds
// R11: Coast stop abandons restart wait
// R12: Every start from idle begins at starting frequency
// R13: Delays counted from clock via tick rate
`ifndef DIP_RESTART_DEFINES_SVH
`define DIP_RESTART_DEFINES_SVH
`define MODE_TRIP_NOW 3'h0
`define MODE_TRIP_AFTER 3'h1
`define MODE_RESTART_SAVED 3'h4
`define MODE_RESTART_START 3'h5
`define CLK_HZ 40000000
`define TICK_HZ 1000
`define DELAY_MS 500
`define WINDOW_MS 2000
`endif

// *** hdl/dip_restart_pkg.sv ***
// Types shared by the power dip restart sequencer
package dip_restart_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RUN = 3'b001,
        ST_DIP = 3'b011,
        ST_WAIT = 3'b010,
        ST_ALARM = 3'b110
    } state_t;
    typedef struct packed {
        logic [15:0] freq;
        logic run;
        logic alarm;
    } drive_t;
endpackage

// *** hdl/power_dip_restart_sequencer.sv ***
// Momentary power failure restart sequencer
`timescale 1ns/1ps
`include "dip_restart_defines.svh"
module power_dip_restart_sequencer #(
    parameter int FW = 16,
    parameter int CLK_HZ = `CLK_HZ,
    parameter int TICK_HZ = `TICK_HZ,
    parameter int DELAY_TICKS = `DELAY_MS * TICK_HZ / 1000,
    parameter int WINDOW_TICKS = `WINDOW_MS * TICK_HZ / 1000
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic UNDERVOLT,
    input wire logic RUN_CMD,
    input wire logic COAST_STOP_CMD,
    input wire logic [2:0] RESTART_MODE_SELECT,
    input wire logic [FW-1:0] START_FREQ_SETTING,
    input wire logic [FW-1:0] TARGET_FREQ,
    input wire logic [FW-1:0] PRESENT_FREQ,
    input wire logic LIMITER_MATCHED,
    output logic OUTPUT_EN,
    output logic [FW-1:0] FREQ_REF,
    output logic ALARM_UV,
    output logic SYNC_RESTART
);
    //------------------------------------------------------------
    // Input synchronisers
    //------------------------------------------------------------
    // Clock cycles per timer tick; CLK_HZ must be a whole multiple of TICK_HZ
    localparam int TICK_DIV = CLK_HZ / TICK_HZ;
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    wire [3:0] raw_in = {UNDERVOLT, RUN_CMD, COAST_STOP_CMD, LIMITER_MATCHED};
    // Two stage catch of pin levels
    always_ff @(posedge CLK) begin
        s1_q <= RST_N ? raw_in : 4'h0;
        s2_q <= RST_N ? s1_q : 4'h0;
    end
    // Synchronised levels seen by the sequencer
    wire uv = s2_q[3];
    wire run = s2_q[2];
    wire coast = s2_q[1];
    wire matched = s2_q[0];

    //------------------------------------------------------------
    // Tick prescaler and timers
    //------------------------------------------------------------
    logic [31:0] pre_q;
    logic [31:0] dly_q;
    logic [31:0] win_q;
    wire tick = (pre_q == 32'(TICK_DIV - 1));
    dip_restart_pkg::state_t st_q, st_d;
    // The first tick after detection may come at once, so one extra tick is
    // counted to keep the delay at or above its full length
    wire dly_done = (dly_q > 32'(DELAY_TICKS)); // R8
    wire win_open = (win_q < 32'(WINDOW_TICKS));
    // Prescaler runs freely; the timers advance only on its tick
    always_ff @(posedge CLK) begin
        if (!RST_N || tick) begin
            pre_q <= 32'h0; // R13
        end else begin
            pre_q <= pre_q + 32'h1;
        end
    end
    // Delay from detection, held until restart; counts saturate
    always_ff @(posedge CLK) begin
        if (!RST_N || st_q == dip_restart_pkg::ST_RUN || st_q == dip_restart_pkg::ST_IDLE) begin
            dly_q <= 32'h0;
        end else if (tick && !dly_done) begin
            dly_q <= dly_q + 32'h1; // R8 R13
        end
    end
    // Window opens when supply recovers
    always_ff @(posedge CLK) begin
        if (!RST_N || st_q != dip_restart_pkg::ST_WAIT) begin
            win_q <= 32'h0;
        end else if (tick && win_open) begin
            win_q <= win_q + 32'h1; // R9 R13
        end
    end

    //------------------------------------------------------------
    // Sequencer
    //------------------------------------------------------------
    logic [FW-1:0] saved_q;
    logic [FW-1:0] freq_q;
    logic [2:0] mode_q;
    logic alarm_q;
    logic sync_q;
    wire mode0 = (mode_q == `MODE_TRIP_NOW);
    wire mode1 = (mode_q == `MODE_TRIP_AFTER);
    wire mode4 = (mode_q == `MODE_RESTART_SAVED);
    wire restart_ok = run && dly_done && win_open && !coast;
    // Saved frequency only within window and mode 4; else start fresh
    wire [FW-1:0] restart_freq = mode4 ? saved_q : START_FREQ_SETTING;

    // Next state; undervoltage has priority over run and coast while running
    always_comb begin
        st_d = st_q;
        case (st_q)
            dip_restart_pkg::ST_IDLE: begin
                if (run && !coast && !uv) begin
                    st_d = dip_restart_pkg::ST_RUN;
                end
            end
            dip_restart_pkg::ST_RUN: begin
                if (uv) begin
                    st_d = mode0 ? dip_restart_pkg::ST_ALARM : dip_restart_pkg::ST_DIP; // R1 R2
                end else if (!run || coast) begin
                    st_d = dip_restart_pkg::ST_IDLE;
                end
            end
            dip_restart_pkg::ST_DIP: begin
                if (coast && !mode1) begin
                    st_d = dip_restart_pkg::ST_IDLE; // R11
                end else if (!uv) begin
                    st_d = mode1 ? dip_restart_pkg::ST_ALARM : dip_restart_pkg::ST_WAIT; // R3
                end
            end
            dip_restart_pkg::ST_WAIT: begin
                if (uv) begin
                    st_d = dip_restart_pkg::ST_DIP;
                end else if (coast || !win_open) begin
                    st_d = dip_restart_pkg::ST_IDLE; // R9 R11
                end else if (restart_ok) begin
                    st_d = dip_restart_pkg::ST_RUN; // R4 R7 R8
                end
            end
            dip_restart_pkg::ST_ALARM: begin
                st_d = dip_restart_pkg::ST_ALARM; // R2
            end
            default: begin
                st_d = dip_restart_pkg::ST_IDLE;
            end
        endcase
    end

    // Event decodes from the present and next state
    wire uv_event = (st_q == dip_restart_pkg::ST_RUN) && uv;
    wire fresh_start = (st_q == dip_restart_pkg::ST_IDLE) && (st_d == dip_restart_pkg::ST_RUN);
    wire dip_restart = (st_q == dip_restart_pkg::ST_WAIT) && (st_d == dip_restart_pkg::ST_RUN);

    // Normal running follows the target; the limiter phase holds the saved value
    wire in_run = (st_q == dip_restart_pkg::ST_RUN);
    wire [FW-1:0] run_freq = sync_q ? saved_q : TARGET_FREQ; // R5
    // Priority: fresh start, then dip restart, then running, else hold
    wire [FW-1:0] freq_d = fresh_start ? START_FREQ_SETTING : // R12
        (dip_restart ? restart_freq : (in_run ? run_freq : freq_q)); // R4 R7
    // Mode is frozen inside a dip so a change mid dip has no effect
    wire mode_hold = (st_q == dip_restart_pkg::ST_DIP) || (st_q == dip_restart_pkg::ST_WAIT);
    // Sync phase: set on a mode 4 restart, cleared on a match or on leaving run
    wire sync_set = dip_restart && mode4;
    wire sync_clr = !in_run || matched;

    // State register
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st_q <= dip_restart_pkg::ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end
    // Restart mode, sampled only outside a dip
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            mode_q <= 3'h0;
        end else if (!mode_hold) begin
            mode_q <= RESTART_MODE_SELECT;
        end
    end
    // Output frequency captured at the moment of failure
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            saved_q <= '0;
        end else if (uv_event) begin
            saved_q <= PRESENT_FREQ; // R4
        end
    end
    // Alarm is sticky: only reset clears it, so a later run cannot hide it
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            alarm_q <= 1'b0;
        end else if (st_d == dip_restart_pkg::ST_ALARM) begin
            alarm_q <= 1'b1; // R2 R3
        end
    end
    // Frequency reference register
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            freq_q <= '0;
        end else begin
            freq_q <= freq_d; // R12
        end
    end
    // Limiter owns frequency until speed matches; a set wins over a clear
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sync_q <= 1'b0;
        end else if (sync_set) begin
            sync_q <= 1'b1; // R5 R6
        end else if (sync_clr) begin
            sync_q <= 1'b0; // R5
        end
    end

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            OUTPUT_EN <= 1'b0;
            FREQ_REF <= '0;
            ALARM_UV <= 1'b0;
            SYNC_RESTART <= 1'b0;
        end else begin
            // Output drops one clock after undervoltage is seen, on the edge that leaves run
            OUTPUT_EN <= (st_q == dip_restart_pkg::ST_RUN) && !uv; // R1
            FREQ_REF <= freq_q;
            ALARM_UV <= alarm_q;
            SYNC_RESTART <= sync_q;
        end
    end
endmodule

// *** sim/dip_restart_monitor.sv ***
// Port checker for the power dip restart sequencer
`timescale 1ns/1ps
module dip_restart_monitor #(
    parameter int FW = 16,
    parameter int CLK_HZ = 40000000,
    parameter int TICK_HZ = 1000,
    parameter int DELAY_TICKS = 500
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic UNDERVOLT,
    input wire logic LIMITER_MATCHED,
    input wire logic OUTPUT_EN,
    input wire logic ALARM_UV,
    input wire logic SYNC_RESTART,
    input wire logic [2:0] RESTART_MODE_SELECT,
    input wire logic [FW-1:0] START_FREQ_SETTING,
    input wire logic [FW-1:0] FREQ_REF
);
    // Full delay in clock cycles; divide first so the product stays in range
    localparam int MIN_OFF = DELAY_TICKS * (CLK_HZ / TICK_HZ);
    logic [31:0] off_q;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // Cycles spent with the output stage off
    always_ff @(posedge CLK) off_q <= (OUTPUT_EN || !RST_N) ? 32'h0 : off_q + 32'h1;
    sequence s_dip_from_run;
        (OUTPUT_EN && UNDERVOLT) ##1 UNDERVOLT [*3];
    endsequence
    property p_uv_off; s_dip_from_run |-> !OUTPUT_EN; endproperty
    a_uv_off: assert property (p_uv_off) else $error("output on after dip");
    property p_trip_now; s_dip_from_run ##0 RESTART_MODE_SELECT == 3'h0 |-> ##[0:2] ALARM_UV;
    endproperty
    a_trip_now: assert property (p_trip_now) else $error("no alarm in mode 0");
    property p_alarm_hold; ALARM_UV |=> ALARM_UV && !OUTPUT_EN; endproperty
    a_alarm_hold: assert property (p_alarm_hold) else $error("alarm not held");
    property p_trip_later; s_dip_from_run ##0 RESTART_MODE_SELECT == 3'h1 |-> !ALARM_UV;
    endproperty
    a_trip_later: assert property (p_trip_later) else $error("early alarm in mode 1");
    property p_start_freq; $rose(OUTPUT_EN) && !SYNC_RESTART |-> FREQ_REF == START_FREQ_SETTING;
    endproperty
    a_start_freq: assert property (p_start_freq) else $error("bad start freq");
    property p_sync_mode; $rose(OUTPUT_EN) && SYNC_RESTART |-> RESTART_MODE_SELECT == 3'h4;
    endproperty
    a_sync_mode: assert property (p_sync_mode) else $error("sync outside mode 4");
    property p_sync_hold; SYNC_RESTART ##1 SYNC_RESTART |-> $stable(FREQ_REF) && OUTPUT_EN;
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("freq moved in sync");
    property p_sync_end; (SYNC_RESTART && LIMITER_MATCHED) ##1 LIMITER_MATCHED [*4] |=>
        !SYNC_RESTART; endproperty
    a_sync_end: assert property (p_sync_end) else $error("sync never ends");
    property p_delay; $rose(SYNC_RESTART) |-> off_q >= 32'(MIN_OFF); endproperty
    a_delay: assert property (p_delay) else $error("restart too soon");
endmodule
bind power_dip_restart_sequencer dip_restart_monitor #(.FW(FW), .CLK_HZ(CLK_HZ),
    .TICK_HZ(TICK_HZ), .DELAY_TICKS(DELAY_TICKS)) u_dip_restart_monitor (.CLK, .RST_N,
    .UNDERVOLT, .LIMITER_MATCHED, .OUTPUT_EN, .ALARM_UV, .SYNC_RESTART, .RESTART_MODE_SELECT,
    .START_FREQ_SETTING, .FREQ_REF);

// *** sim/drive_stage_model.sv ***
// Output stage and motor speed model behind the sequencer
`timescale 1ns/1ps
module drive_stage_model (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic OUTPUT_EN,
    input wire logic [15:0] FREQ_REF,
    output logic [15:0] PRESENT_FREQ,
    output logic LIMITER_MATCHED
);
    logic [3:0] age_q;
    logic en_q;
    // Speed tracks the reference when driven; a coasting motor slows after a while
    always_ff @(posedge CLK) begin
        en_q <= OUTPUT_EN;
        age_q <= (!RST_N || en_q != OUTPUT_EN) ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
        if (!RST_N) PRESENT_FREQ <= 16'h0000;
        else if (OUTPUT_EN) PRESENT_FREQ <= FREQ_REF;
        else if (age_q == 4'hF && PRESENT_FREQ != 16'h0000) PRESENT_FREQ <= PRESENT_FREQ - 16'h0001;
    end
    // Surge limiter enabled, so a match is reported once the restarted speed settles
    assign LIMITER_MATCHED = OUTPUT_EN && age_q == 4'hF;
endmodule

// *** sim/power_dip_restart_sequencer_bench.sv ***
// Self-checking bench for the power dip restart sequencer
`timescale 1ns/1ps
module power_dip_restart_sequencer_bench;
    logic CLK, RST_N, UNDERVOLT, RUN_CMD, COAST_STOP_CMD, LIMITER_MATCHED;
    logic OUTPUT_EN, ALARM_UV, SYNC_RESTART;
    logic [2:0] RESTART_MODE_SELECT;
    logic [15:0] START_FREQ_SETTING, TARGET_FREQ, PRESENT_FREQ, FREQ_REF;
    int miscompares, cmp_count, cycles, n;
    // Rows: mode, alarm expected, restart expected, sync phase expected
    logic [5:0] rows [4] = '{6'b000_1_0_0, 6'b001_1_0_0, 6'b100_0_1_1, 6'b101_0_1_0};
    power_dip_restart_sequencer #(.CLK_HZ(40), .TICK_HZ(10), .DELAY_TICKS(5),
        .WINDOW_TICKS(20)) u_power_dip_restart_sequencer (.CLK(CLK), .RST_N(RST_N),
        .UNDERVOLT(UNDERVOLT), .RUN_CMD(RUN_CMD), .COAST_STOP_CMD(COAST_STOP_CMD),
        .RESTART_MODE_SELECT(RESTART_MODE_SELECT), .START_FREQ_SETTING(START_FREQ_SETTING),
        .TARGET_FREQ(TARGET_FREQ), .PRESENT_FREQ(PRESENT_FREQ),
        .LIMITER_MATCHED(LIMITER_MATCHED), .OUTPUT_EN(OUTPUT_EN), .FREQ_REF(FREQ_REF),
        .ALARM_UV(ALARM_UV), .SYNC_RESTART(SYNC_RESTART));
    drive_stage_model u_drive_stage_model (.CLK(CLK), .RST_N(RST_N), .OUTPUT_EN(OUTPUT_EN),
        .FREQ_REF(FREQ_REF), .PRESENT_FREQ(PRESENT_FREQ), .LIMITER_MATCHED(LIMITER_MATCHED));
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    // Hang guard, well above the planned run length
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            miscompares++;
            final_report;
        end
    end
    task automatic check(logic [15:0] got, logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Samples on the falling edge so outputs have settled
    task automatic tick(int c);
        repeat (c) @(negedge CLK);
    endtask
    task automatic do_reset(logic [2:0] mode);
        @(posedge CLK);
        RST_N <= 1'b0;
        RUN_CMD <= 1'b0;
        // A dip left standing by the last start would block the next run
        UNDERVOLT <= 1'b0;
        COAST_STOP_CMD <= 1'b0;
        RESTART_MODE_SELECT <= mode;
        repeat (12) @(posedge CLK);
        RST_N <= 1'b1;
        tick(1);
        check({OUTPUT_EN, ALARM_UV, SYNC_RESTART, FREQ_REF[12:0]}, 16'h0000);
    endtask
    task automatic start_run;
        @(posedge CLK);
        RUN_CMD <= 1'b1;
        for (n = 0; n < 200 && OUTPUT_EN !== 1'b1; n++) tick(1);
        check(FREQ_REF, START_FREQ_SETTING);
        tick(10);
        @(posedge CLK);
        UNDERVOLT <= 1'b1;
    endtask
    task automatic final_report;
        $display("comparisons %0d, miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        RST_N = 1'b0;
        {UNDERVOLT, RUN_CMD, COAST_STOP_CMD, RESTART_MODE_SELECT} = 6'h00;
        START_FREQ_SETTING = 16'h0010;
        TARGET_FREQ = 16'h0300;
        // Short dips with the run command latched through them
        foreach (rows[i]) begin
            do_reset(rows[i][5:3]);
            start_run;
            repeat (4) @(posedge CLK);
            UNDERVOLT <= 1'b0;
            if (rows[i][1]) begin
                for (n = 0; n < 200 && OUTPUT_EN !== 1'b1; n++) tick(1);
                // Detection is three edges before the count starts: 5 ticks of 4 cycles
                check(16'(n >= 20), 16'h0001);
                check(FREQ_REF, rows[i][0] ? TARGET_FREQ : START_FREQ_SETTING);
                check(16'(SYNC_RESTART), 16'(rows[i][0]));
                for (n = 0; n < 200 && SYNC_RESTART !== 1'b0; n++) tick(1);
                tick(3);
                check(FREQ_REF, TARGET_FREQ);
            end else tick(150);
            check({OUTPUT_EN, ALARM_UV}, {14'h0000, rows[i][1], rows[i][2]});
        end
        // Run dropped past the window, then a coast stop during the dip
        for (int k = 0; k < 2; k++) begin
            do_reset(3'h4);
            start_run;
            @(posedge CLK);
            RUN_CMD <= k[0];
            COAST_STOP_CMD <= k[0];
            repeat (3) @(posedge CLK);
            UNDERVOLT <= 1'b0;
            tick(k ? 40 : 130);
            check(16'(OUTPUT_EN), 16'h0000);
            @(posedge CLK);
            {RUN_CMD, COAST_STOP_CMD} <= 2'h0;
            tick(4);
            start_run;
        end
        final_report;
    end
endmodule
